/* logic/raw_pre_pkg.sv */
/*
  shared constants and types of the raw sensor pre-processing stage.
  assumes a 16-bit register port and 14-bit sensor samples.
*/
package raw_pre_pkg;
  // register indices on the plain port (word address)
  localparam logic [4:0] ADDR_START_LOW  = 5'h00;
  localparam logic [4:0] ADDR_START_HIGH = 5'h01;
  localparam logic [4:0] ADDR_CLAMP      = 5'h02;
  localparam logic [4:0] ADDR_DC_SUB     = 5'h03;
  localparam logic [4:0] ADDR_COLOUR     = 5'h04;
  localparam logic [4:0] ADDR_BLK_FIRST  = 5'h05;
  localparam logic [4:0] ADDR_BLK_SECOND = 5'h06;
  localparam logic [4:0] ADDR_MEDIAN     = 5'h07;
  localparam logic [4:0] ADDR_GAIN_BASE  = 5'h08;  // four gains at 08..0B
  localparam logic [4:0] ADDR_OFFSET     = 5'h0C;
  localparam logic [4:0] ADDR_CLIP       = 5'h0D;
  localparam logic [4:0] ADDR_CONFIG     = 5'h0E;  // bit0 stripe pattern
  localparam logic [4:0] ADDR_BLACK_AVG  = 5'h0F;  // read only
  // field positions
  localparam int CLAMP_EN_BIT  = 15;
  localparam int LINE_CNT_LSB  = 14;
  localparam int PIX_CNT_LSB   = 13;
  // reset values
  localparam logic [15:0] GAIN_RESET = 16'h0100;
  localparam logic [15:0] CLIP_RESET = 16'h3FFF;
  localparam logic [15:0] ZERO_RESET = 16'h0000;
  // widths
  localparam int PIX_W = 14;

  // register port request
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // one sample with its sync levels
  typedef struct packed {
    logic [13:0] data;
    logic        hsync;
    logic        vsync;
    logic        field;
  } sensor_in_t;
endpackage : raw_pre_pkg

/* logic/raw_pre_core.sv */
/*
  raw sensor conditioning: clamp/dc, black level, gain, offset, clip.
  assumes sensor pins and pixel clock are asynchronous to ref_clk and
  that the pixel clock runs well below half of ref_clk.
*/
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
// Function
// - low 16 start-address bits, 32-byte units
// - upper 7 address bits joined above
// - frame-latched settings copied at vertical sync
// - clamp enable subtracts optical-black average
// - pixel count code gives 2/4/8/16
// - black sampling starts at programmed pixel
// - line count code gives 2/4/8/16
// - clamp off subtracts DC constant
// - four two-bit colour codes per field
// - mosaic maps positions by line parity
// - stripe maps positions 0..2 per line
// - signed R/Ye and Black_comp_green_red_cyan black correction
// - signed Gb/G and B/Mg black correction
// - 14-bit median threshold held
// - per-colour U11Q8 gain, reset unity
// - 10-bit offset added after gain
// - clip result to programmed maximum
`timescale 1ns/1ps
module raw_pre_core (
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  input  wire raw_pre_pkg::reg_req_t  regReq,
  output logic [15:0]                 regRdata,
  input  wire logic                   pixClk,
  input  wire raw_pre_pkg::sensor_in_t sensorIn,
  output logic [13:0]                 pixOut,
  output logic                        pixValid,
  output logic [22:0]                 captureStart,
  output logic [13:0]                 medianThreshold
);
  import raw_pre_pkg::*;

  // software-side shadow registers
  logic [15:0] startLow_reg, startHigh_reg, clamp_reg, dc_level_subtract_reg, colour_reg;
  logic [15:0] blkFirst_reg, blkSecond_reg, median_reg, offset_reg, clip_reg, config_reg;
  logic [15:0] gain_reg [4];
  // active copies, loaded at vertical sync only
  logic [15:0] aStartLow_reg, aStartHigh_reg, aClamp_reg, aDcSub_reg, aColour_reg;
  logic [15:0] aBlkFirst_reg, aBlkSecond_reg, aOffset_reg, aConfig_reg;
  logic [15:0] aGain_reg [4];

  // register writes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      startLow_reg  <= ZERO_RESET;
      startHigh_reg <= ZERO_RESET;
      clamp_reg     <= ZERO_RESET;
      dc_level_subtract_reg     <= ZERO_RESET;
      colour_reg    <= ZERO_RESET;
      blkFirst_reg  <= ZERO_RESET;
      blkSecond_reg <= ZERO_RESET;
      median_reg    <= ZERO_RESET;
      offset_reg    <= ZERO_RESET;
      clip_reg      <= CLIP_RESET;
      config_reg    <= ZERO_RESET;
    end else if (regReq.wr) begin
      case (regReq.addr)
        ADDR_START_LOW:  startLow_reg  <= regReq.wdata;
        ADDR_START_HIGH: startHigh_reg <= {9'h000, regReq.wdata[6:0]};
        ADDR_CLAMP:      clamp_reg     <= regReq.wdata;
        ADDR_DC_SUB:     dc_level_subtract_reg     <= regReq.wdata;
        ADDR_COLOUR:     colour_reg    <= regReq.wdata;
        ADDR_BLK_FIRST:  blkFirst_reg  <= regReq.wdata;
        ADDR_BLK_SECOND: blkSecond_reg <= regReq.wdata;
        ADDR_MEDIAN:     median_reg    <= {2'h0, regReq.wdata[13:0]};
        ADDR_OFFSET:     offset_reg    <= {6'h00, regReq.wdata[9:0]};
        ADDR_CLIP:       clip_reg      <= {2'h0, regReq.wdata[13:0]};
        ADDR_CONFIG:     config_reg    <= {15'h0000, regReq.wdata[0]};
        default: ;  // unmapped or gain: ignored here
      endcase
    end
  end

  // gain registers, one per colour class
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gGain
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          gain_reg[g] <= GAIN_RESET;
        end else if (regReq.wr && regReq.addr == ADDR_GAIN_BASE + 5'(g)) begin
          gain_reg[g] <= {5'h00, regReq.wdata[10:0]};
        end
      end
    end
  endgenerate

  // two-flop synchronisers for every pin
  logic [17:0] sync1_reg, sync2_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {pixClk, sensorIn};
      sync2_reg <= sync1_reg;
    end
  end
  // data is sampled on the synced pixel clock edge; it is stable then
  // because the sender holds it for a whole pixel period
  logic        pclkS, pclkD_reg, hsS, hsD_reg, vsS, vsD_reg, fieldS;
  logic [13:0] dataS;
  assign pclkS  = sync2_reg[17];
  assign dataS  = sync2_reg[16:3];
  assign hsS    = sync2_reg[2];
  assign vsS    = sync2_reg[1];
  assign fieldS = sync2_reg[0];
  logic pixEdge, hsEdge, vsEdge;

  // edge detection on the synced levels
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pclkD_reg <= 1'b0;
      hsD_reg   <= 1'b0;
      vsD_reg   <= 1'b0;
    end else begin
      pclkD_reg <= pclkS;
      hsD_reg   <= hsS;
      vsD_reg   <= vsS;
    end
  end
  assign pixEdge = pclkS & ~pclkD_reg;
  assign hsEdge  = hsS & ~hsD_reg;
  assign vsEdge  = vsS & ~vsD_reg;

  // frame latch: copy shadows into the active path at vertical sync
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aStartLow_reg  <= ZERO_RESET;
      aStartHigh_reg <= ZERO_RESET;
      aClamp_reg     <= ZERO_RESET;
      aDcSub_reg     <= ZERO_RESET;
      aColour_reg    <= ZERO_RESET;
      aBlkFirst_reg  <= ZERO_RESET;
      aBlkSecond_reg <= ZERO_RESET;
      aOffset_reg    <= ZERO_RESET;
      aConfig_reg    <= ZERO_RESET;
      for (int i = 0; i < 4; i++) aGain_reg[i] <= GAIN_RESET;
    end else if (vsEdge) begin
      aStartLow_reg  <= startLow_reg;
      aStartHigh_reg <= startHigh_reg;
      aClamp_reg     <= clamp_reg;
      aDcSub_reg     <= dc_level_subtract_reg;
      aColour_reg    <= colour_reg;
      aBlkFirst_reg  <= blkFirst_reg;
      aBlkSecond_reg <= blkSecond_reg;
      aOffset_reg    <= offset_reg;
      aConfig_reg    <= config_reg;
      for (int i = 0; i < 4; i++) aGain_reg[i] <= gain_reg[i];
    end
  end

  // pixel and line counters from horizontal / vertical sync
  logic [12:0] pixCnt_reg;
  logic [4:0]  lineCnt_reg;
  logic        lineOdd_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pixCnt_reg  <= '0;
      lineCnt_reg <= '0;
      lineOdd_reg <= 1'b0;
    end else if (vsEdge) begin
      pixCnt_reg  <= '0;
      lineCnt_reg <= '0;
      lineOdd_reg <= 1'b0;
    end else if (hsEdge) begin
      pixCnt_reg  <= '0;
      lineOdd_reg <= ~lineOdd_reg;
      if (lineCnt_reg != 5'h1F) lineCnt_reg <= lineCnt_reg + 5'h01;
    end else if (pixEdge && pixCnt_reg != 13'h1FFF) begin
      pixCnt_reg <= pixCnt_reg + 13'h0001;
    end
  end

  // optical-black window and averaging
  logic [4:0]  obPixN, obLineN;
  logic [12:0] obStart, obEnd;
  logic        inObWin;
  logic [22:0] obSum_reg;
  logic [13:0] obAvg_reg;
  assign obPixN  = 5'h02 << aClamp_reg[PIX_CNT_LSB +: 2];
  assign obLineN = 5'h02 << aDcSub_reg[LINE_CNT_LSB +: 2];
  assign obStart = aClamp_reg[12:0];
  assign obEnd   = obStart + 13'(obPixN);
  assign inObWin = pixEdge && pixCnt_reg >= obStart && pixCnt_reg < obEnd
                   && lineCnt_reg < obLineN;
  // sum resets each frame; average taken by shift once all lines done
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      obSum_reg <= '0;
      obAvg_reg <= '0;
    end else if (vsEdge) begin
      obSum_reg <= '0;
    end else begin
      if (inObWin) obSum_reg <= obSum_reg + 23'(dataS);
      // the hsync that closes the last sampled line publishes the average,
      // so the very next line is already clamped with it
      if (hsEdge && lineCnt_reg == obLineN - 5'h01) begin
        obAvg_reg <= 14'(obSum_reg >> (aClamp_reg[14:13] + aDcSub_reg[15:14] + 2));
      end
    end
  end

  // colour class from field, line parity and pixel count
  logic [1:0] position, colourClass;
  logic [7:0] fieldCodes;
  always_comb begin
    fieldCodes = fieldS ? aColour_reg[15:8] : aColour_reg[7:0];
    if (aConfig_reg[0]) begin
      // stripe: position 3 never chosen
      position = (pixCnt_reg % 13'd3 == 13'd0) ? 2'd0 :
                 (pixCnt_reg % 13'd3 == 13'd1) ? 2'd1 : 2'd2;
    end else begin
      position = {lineOdd_reg, pixCnt_reg[0]};
    end
    colourClass = fieldCodes[7 - 2*position -: 2];
  end

  // arithmetic chain
  logic signed [15:0] afterClamp, afterBlack;
  logic [13:0]        clampSat;
  logic signed [7:0]  blackCorr;
  logic [10:0]        gain;
  logic [27:0]        product;
  logic [20:0]        withOffset;
  logic [13:0]        clipped;
  always_comb begin
    afterClamp = aClamp_reg[CLAMP_EN_BIT]
               ? $signed({2'b00, dataS}) - $signed({2'b00, obAvg_reg})
               : $signed({2'b00, dataS}) - $signed({2'b00, aDcSub_reg[13:0]});
    clampSat = afterClamp < 0 ? 14'h0000 : afterClamp[13:0];
    case (colourClass)
      2'd0:    blackCorr = $signed(aBlkFirst_reg[15:8]);
      2'd1:    blackCorr = $signed(aBlkFirst_reg[7:0]);
      2'd2:    blackCorr = $signed(aBlkSecond_reg[15:8]);
      default: blackCorr = $signed(aBlkSecond_reg[7:0]);
    endcase
    afterBlack = $signed({2'b00, clampSat}) + 16'(blackCorr);
    gain       = aGain_reg[colourClass][10:0];
    product    = (afterBlack < 0 ? 15'h0000 : 15'(afterBlack)) * {4'h0, gain};
    withOffset = 21'(product >> 8) + {11'h000, aOffset_reg[9:0]};
    clipped    = withOffset > {7'h00, clip_reg[13:0]} ? clip_reg[13:0]
                                                      : withOffset[13:0];
  end

  // output stage: one result per pixel clock edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pixOut   <= '0;
      pixValid <= 1'b0;
    end else begin
      pixValid <= pixEdge;
      if (pixEdge) pixOut <= clipped;
    end
  end

  // capture address and threshold outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      captureStart    <= '0;
      medianThreshold <= '0;
    end else begin
      captureStart    <= {aStartHigh_reg[6:0], aStartLow_reg};
      medianThreshold <= median_reg[13:0];
    end
  end

  // read port: data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= '0;
    end else if (regReq.rd) begin
      case (regReq.addr)
        ADDR_START_LOW:  regRdata <= startLow_reg;
        ADDR_START_HIGH: regRdata <= startHigh_reg;
        ADDR_CLAMP:      regRdata <= clamp_reg;
        ADDR_DC_SUB:     regRdata <= dc_level_subtract_reg;
        ADDR_COLOUR:     regRdata <= colour_reg;
        ADDR_BLK_FIRST:  regRdata <= blkFirst_reg;
        ADDR_BLK_SECOND: regRdata <= blkSecond_reg;
        ADDR_MEDIAN:     regRdata <= median_reg;
        5'h08:           regRdata <= gain_reg[0];
        5'h09:           regRdata <= gain_reg[1];
        5'h0A:           regRdata <= gain_reg[2];
        5'h0B:           regRdata <= gain_reg[3];
        ADDR_OFFSET:     regRdata <= offset_reg;
        ADDR_CLIP:       regRdata <= clip_reg;
        ADDR_CONFIG:     regRdata <= config_reg;
        ADDR_BLACK_AVG:  regRdata <= {2'h0, obAvg_reg};
        default:         regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // checks
  AST_LATCH_AT_VSYNC: assert property (@(posedge ref_clk) disable iff (!nrst)
    !vsEdge |=> $stable(aGain_reg[0]) && $stable(aClamp_reg))
    else $error("active setting changed outside vertical sync");
  AST_CLIP_BOUND: assert property (@(posedge ref_clk) disable iff (!nrst)
    pixValid |-> pixOut <= clip_reg[13:0])
    else $error("output above clip value");
  AST_VALID_PULSE: assert property (@(posedge ref_clk) disable iff (!nrst)
    pixEdge |=> pixValid ##1 !pixValid)
    else $error("valid not a single pulse per pixel edge");
  AST_ADDR_JOIN: assert property (@(posedge ref_clk) disable iff (!nrst)
    vsEdge |=> ##1 captureStart == {$past(startHigh_reg[6:0], 2), $past(startLow_reg, 2)})
    else $error("start address not joined");
  AST_GAIN_RESET: assert property (@(posedge ref_clk)
    $rose(nrst) |-> gain_reg[0] == GAIN_RESET)
    else $error("gain not unity after reset");
  AST_STRIPE_POS: assert property (@(posedge ref_clk) disable iff (!nrst)
    aConfig_reg[0] |-> position != 2'd3)
    else $error("stripe used position 3");
  AST_MOSAIC_POS: assert property (@(posedge ref_clk) disable iff (!nrst)
    !aConfig_reg[0] |-> position == {lineOdd_reg, pixCnt_reg[0]})
    else $error("mosaic position wrong");
  AST_NO_NEG: assert property (@(posedge ref_clk) disable iff (!nrst)
    afterClamp < 0 |-> clampSat == 14'h0000)
    else $error("negative not saturated");
  AST_DC_PATH: assert property (@(posedge ref_clk) disable iff (!nrst)
    !aClamp_reg[CLAMP_EN_BIT] && dataS >= aDcSub_reg[13:0]
      |-> clampSat == dataS - aDcSub_reg[13:0])
    else $error("dc subtraction wrong");
  COV_VSYNC:  cover property (@(posedge ref_clk) vsEdge);
  COV_CLAMP:  cover property (@(posedge ref_clk) aClamp_reg[CLAMP_EN_BIT] && pixValid);
  COV_CLIP:   cover property (@(posedge ref_clk) pixValid && pixOut == clip_reg[13:0]);
  COV_STRIPE: cover property (@(posedge ref_clk) aConfig_reg[0] && position == 2'd2);
endmodule : raw_pre_core

/* dv/sensor_model.sv */
/*
  image sensor model: drives samples, sync pulses and the pixel clock.
  assumes the bench calls its tasks one at a time from one process.
*/
`timescale 1ns/1ps
module sensor_model (
  output logic                   pixClk,
  output raw_pre_pkg::sensor_in_t sensorIn
);
  import raw_pre_pkg::*;
  // clock stands still outside frames
  initial begin
    pixClk   = 1'b0;
    sensorIn = '0;
  end
  // one pixel, data settles half a period before the rise
  task automatic pixel(input logic [13:0] d);
    sensorIn.data = d;
    #32 pixClk = 1'b1;
    #32 pixClk = 1'b0;
    sensorIn.data = ~d;  // hold time over, no stale value left
  endtask : pixel
  // vertical or horizontal sync pulse, field level set with it
  task automatic pulse(input bit v, input bit f);
    sensorIn.field = f;
    if (v) sensorIn.vsync = 1'b1;
    else sensorIn.hsync = 1'b1;
    #64 sensorIn.vsync = 1'b0;
    sensorIn.hsync = 1'b0;
    #64;
  endtask : pulse
endmodule : sensor_model

/* dv/raw_pre_core_tb_top.sv */
/*
  self-checking bench of the raw conditioning stage.
  assumes the sensor model in its own file and the design package.
*/
`timescale 1ns/1ps
module raw_pre_core_tb_top;
  import raw_pre_pkg::*;
  logic        ref_clk;           // 125 MHz
  logic        nrst;              // active low
  reg_req_t    regReq;            // register port
  logic [15:0] regRdata;          // read data
  logic        pixClk;            // link clock from model
  sensor_in_t  sensorIn;          // samples and syncs
  logic [13:0] pixOut;            // processed pixel
  logic        pixValid;          // pixel strobe
  logic [22:0] captureStart;      // active start address
  logic [13:0] medianThreshold;   // threshold output
  int          errorCnt;          // mismatches
  int          checksDone;        // comparisons
  logic [31:0] rs;                // xorshift state
  int          expQ[$];           // expected pixels, -1 = unchecked
  int          subVal;            // model: dc level
  int          offVal;            // model: offset
  int          clipVal;           // model: clip
  logic [15:0] cp;                // model: colour map
  logic [7:0]  blk[4];            // model: black levels
  int          gain[4];           // model: gains
  logic [15:0] rdv;               // read scratch

  raw_pre_core raw_pre_core_i (.ref_clk(ref_clk), .nrst(nrst), .regReq(regReq),
    .regRdata(regRdata), .pixClk(pixClk), .sensorIn(sensorIn), .pixOut(pixOut),
    .pixValid(pixValid), .captureStart(captureStart), .medianThreshold(medianThreshold));
  sensor_model sensor_model_i (.pixClk(pixClk), .sensorIn(sensorIn));

  // free-running system clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] rnd16();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[15:0];
  endfunction : rnd16

  // reference of one pixel; the dc and black stages floor at zero
  function automatic int expect_pix(int x, int c, int sb);
    int s;
    s = x - sb;
    if (s < 0) s = 0;
    s = s + int'($signed(blk[c]));
    if (s < 0) s = 0;
    s = ((s * gain[c]) >> 8) + offVal;
    return (s > clipVal) ? clipVal : s;
  endfunction : expect_pix

  task automatic cmp(input logic [22:0] got, input logic [22:0] exp);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    regReq.wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    regReq.rd <= 1'b0;
    #1 cmp(regRdata, exp);
  endtask : rdchk

  // random settings for the next frame; v >= 0 turns the clamp on
  task automatic setup(input bit m, input int v);
    subVal = rnd16() & 16'h03FF;
    wr(ADDR_DC_SUB, 16'(subVal));  // line count code 0: two lines
    cp = rnd16();
    wr(ADDR_COLOUR, cp);
    {blk[0], blk[1], blk[2], blk[3]} = {rnd16(), rnd16()};
    wr(ADDR_BLK_FIRST, {blk[0], blk[1]});
    wr(ADDR_BLK_SECOND, {blk[2], blk[3]});
    for (int g = 0; g < 4; g++) begin
      gain[g] = rnd16() & 16'h07FF;
      wr(ADDR_GAIN_BASE + 5'(g), 16'(gain[g]));
    end
    offVal = rnd16() & 16'h03FF;
    wr(ADDR_OFFSET, 16'(offVal));
    clipVal = 16'h3FFF - (rnd16() & 16'h0FFF);
    wr(ADDR_CLIP, 16'(clipVal));
    wr(ADDR_CONFIG, {15'h0000, m});
    // raw samples only, so clamping is allowed; two pixels from count 1
    wr(ADDR_CLAMP, (v < 0) ? 16'h0000 : 16'h8001);
  endtask : setup

  // four lines of six pixels; gains rewritten mid-frame must not act
  task automatic frame(input bit m, input bit f, input int v);
    int pos;
    logic [13:0] d;
    sensor_model_i.pulse(1'b1, f);
    for (int g = 0; g < 4; g++) wr(ADDR_GAIN_BASE + 5'(g), rnd16());
    for (int ln = 0; ln < 4; ln++) begin
      if (ln > 0) sensor_model_i.pulse(1'b0, f);
      for (int pc = 0; pc < 6; pc++) begin
        d = (v < 0) ? 14'(rnd16()) : 14'(v);
        pos = m ? pc % 3 : (ln % 2) * 2 + pc % 2;
        expQ.push_back((v >= 0 && ln < 2) ? -1
          : expect_pix(d, cp[(f ? 14 : 6) - 2 * pos +: 2], (v < 0) ? subVal : v));
        sensor_model_i.pixel(d);
      end
    end
    repeat (10) @(posedge ref_clk);
  endtask : frame

  // output pixels against the queue
  always @(posedge ref_clk) begin
    if (pixValid === 1'b1) begin
      if (expQ.size() == 0) cmp(pixOut, 23'h7FFFFF);
      else if (expQ[0] < 0) void'(expQ.pop_front());
      else cmp(pixOut, 23'(expQ.pop_front()));
    end
  end

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", errorCnt, checksDone);
    if (errorCnt == 0 && checksDone > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // watchdog, far beyond the few frames sent
  initial begin
    #300000;
    errorCnt++;
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0;
    regReq = '0;
    rs = 32'd91877;
    errorCnt = 0;
    checksDone = 0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    // reset values, then an unmapped index
    for (int i = 0; i < 16; i++) rdchk(5'(i), (i >= 8 && i <= 11) ? 16'h0100
      : (i == 13) ? 16'h3FFF : 16'h0000);
    rdchk(5'h1F, 16'h0000);
    foreach (cp[i]) begin
      rdv = rnd16();
      wr(5'(i % 7), rdv);
      if (i % 7 inside {0, 4, 5, 6}) rdchk(5'(i % 7), rdv);
    end
    rdv = rnd16() & 16'h3FFF;
    wr(ADDR_MEDIAN, rdv);
    repeat (2) @(posedge ref_clk);
    cmp(medianThreshold, rdv);
    wr(ADDR_START_HIGH, 16'h005A);
    wr(ADDR_START_LOW, 16'hC3E1);
    cmp(captureStart, 23'h000000);
    sensor_model_i.pulse(1'b1, 1'b0);
    cmp(captureStart, {7'h5A, 16'hC3E1});
    for (int k = 0; k < 4; k++) begin
      setup(k[1], -1);
      frame(k[1], k[0], -1);
    end
    // constant black level, clamp replaces the dc level
    setup(1'b0, 1200);
    frame(1'b0, 1'b1, 1200);
    rdchk(ADDR_BLACK_AVG, 16'd1200);
    cmp(23'(expQ.size()), 23'h000000);
    tally_and_finish();
  end
endmodule : raw_pre_core_tb_top
